// ===== hw/qcim_bank.sv
// Purpose: capability, version and vector mask register bank with doorbells
// Assumes: one clock, plain strobe bus, vector events on the same clock
// Notes: read data appear the cycle after the read strobe, else zero

module qcim_bank #(
  parameter logic [3:0] DB_SPACING_EXP = 4'h0,
  parameter logic [7:0] READY_UNITS = 8'h14,
  parameter logic [1:0] ARB_OPTS = 2'h0,
  parameter logic CONTIG_NEED = 1'b1,
  parameter logic [15:0] MAX_DEPTH = 16'h00ff,
  parameter logic [15:0] MAJOR_REV = 16'h00a5, // arbitrary value
  parameter logic [15:0] MINOR_REV = 16'h005a  // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire qcim_pkg::qcim_req_t bus_req,
  input wire logic [31:0] vec_event,
  output logic [31:0] rd_data_ff,
  output logic [31:0] vec_mask_ff,
  output logic irq_ff,
  output logic db_valid_ff,
  output qcim_pkg::qcim_db_t db_ff
);

  // ==========================================================================
  // decode helpers
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    return a == ofs;
  endfunction

  // offset inside the doorbell area, zero outside it
  function automatic logic [15:0] db_ofs(input logic [15:0] a);
    return (a >= qcim_pkg::OFS_DB_BASE) ? 16'(a - qcim_pkg::OFS_DB_BASE)
                                        : 16'h0000;
  endfunction

  // a doorbell write counts only on a stride boundary
  function automatic logic db_aligned(input logic [15:0] ofs,
                                      input logic [3:0] exp);
    logic [15:0] lowm;
    lowm = 16'((16'h0004 << exp) - 16'h0001);
    return (ofs & lowm) == 16'h0000;
  endfunction

  function automatic logic [15:0] db_slot(input logic [15:0] ofs,
                                          input logic [3:0] exp);
    logic [4:0] sh;
    sh = 5'(exp) + 5'h02;
    return ofs >> sh;
  endfunction

  // ==========================================================================
  // submodules
  logic [63:0] cap_w;
  logic [31:0] ver_w;
  logic [31:0] pend_w;
  logic [31:0] mask_w;
  logic mset_we;
  logic mclr_we;
  logic pend_we;
  logic msix_mode;
  qcim_pkg::qcim_imode_t imode_ff;

  qcim_cap_rom #(
    .DB_SPACING_EXP(DB_SPACING_EXP),
    .READY_UNITS(READY_UNITS),
    .ARB_OPTS(ARB_OPTS),
    .CONTIG_NEED(CONTIG_NEED),
    .MAX_DEPTH(MAX_DEPTH),
    .MAJOR_REV(MAJOR_REV),
    .MINOR_REV(MINOR_REV)
  ) u_cap (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .cap_ff(cap_w),
    .ver_ff(ver_w)
  );

  assign msix_mode = (imode_ff == qcim_pkg::QCIM_IRQ_MSIX);
  // in MSI-X the per-vector table owns masking, so these writes are dropped
  assign mset_we = bus_req.wr && hit(bus_req.addr, qcim_pkg::OFS_MASK_SET)
                   && !msix_mode;
  assign mclr_we = bus_req.wr && hit(bus_req.addr, qcim_pkg::OFS_MASK_CLR)
                   && !msix_mode;
  assign pend_we = bus_req.wr && hit(bus_req.addr, qcim_pkg::OFS_PEND);

  qcim_vec_mask #(
    .NVEC(32)
  ) u_mask (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .mask_set_we(mset_we),
    .mask_clr_we(mclr_we),
    .pend_clr_we(pend_we),
    .wr_bits(bus_req.wdata),
    .vec_event(vec_event),
    .mask_ff(mask_w),
    .pend_ff(pend_w)
  );

  assign vec_mask_ff = mask_w;

  // ==========================================================================
  // interrupt mode register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      imode_ff <= qcim_pkg::QCIM_IRQ_PIN;
    end else if (bus_req.wr && hit(bus_req.addr, qcim_pkg::OFS_IMODE)) begin
      imode_ff <= qcim_pkg::qcim_imode_t'(bus_req.wdata[1:0]);
    end
  end

  // ==========================================================================
  // read path
  logic [31:0] nxt_rd_data;

  always_comb begin
    nxt_rd_data = 32'h0000_0000;
    if (bus_req.rd) begin
      if (hit(bus_req.addr, qcim_pkg::OFS_CAP_LO)) begin
        nxt_rd_data = cap_w[31:0];
      end else if (hit(bus_req.addr, qcim_pkg::OFS_CAP_HI)) begin
        nxt_rd_data = cap_w[63:32];
      end else if (hit(bus_req.addr, qcim_pkg::OFS_VER)) begin
        nxt_rd_data = ver_w;
      end else if (hit(bus_req.addr, qcim_pkg::OFS_MASK_SET) ||
                   hit(bus_req.addr, qcim_pkg::OFS_MASK_CLR)) begin
        nxt_rd_data = mask_w;
      end else if (hit(bus_req.addr, qcim_pkg::OFS_PEND)) begin
        nxt_rd_data = pend_w;
      end else if (hit(bus_req.addr, qcim_pkg::OFS_IMODE)) begin
        nxt_rd_data = {30'h0000_0000, imode_ff};
      end
    end
  end

  // writes to capability and version fall through here untouched
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data_ff <= 32'h0000_0000;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // ==========================================================================
  // interrupt output
  logic nxt_irq;

  always_comb begin
    if (msix_mode) begin
      nxt_irq = |pend_w;
    end else begin
      nxt_irq = |(pend_w & ~mask_w);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // ==========================================================================
  // doorbell decode
  // slots alternate submission then completion per queue
  logic [15:0] wofs;
  logic db_hit;
  logic [15:0] wslot;

  assign wofs = db_ofs(bus_req.addr);
  assign db_hit = bus_req.wr && (bus_req.addr >= qcim_pkg::OFS_DB_BASE)
                  && db_aligned(wofs, DB_SPACING_EXP);
  assign wslot = db_slot(wofs, DB_SPACING_EXP);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      db_valid_ff <= 1'b0;
    end else begin
      db_valid_ff <= db_hit;
    end
  end

  // full word captured whatever the stride, gap bytes never decode
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      db_ff <= '0;
    end else if (db_hit) begin
      db_ff.qid <= wslot[15:1];
      db_ff.is_cq <= wslot[0];
      db_ff.value <= bus_req.wdata;
    end
  end

  // ==========================================================================
  // checks
  stride_field_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    bus_req.rd && hit(bus_req.addr, qcim_pkg::OFS_CAP_HI)
    |=> rd_data_ff[3:0] == DB_SPACING_EXP
  ) else $error("doorbell spacing field wrong");

  stride_slot_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    bus_req.wr && bus_req.addr == 16'(qcim_pkg::OFS_DB_BASE +
      (16'h0004 << DB_SPACING_EXP))
    |=> db_valid_ff && db_ff.qid == 15'h0000 && db_ff.is_cq
  ) else $error("second doorbell slot not at one stride");

  db_word_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    db_hit |=> db_valid_ff && db_ff.value == $past(bus_req.wdata)
  ) else $error("doorbell word not captured whole");

  db_gap_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    bus_req.wr && !db_aligned(db_ofs(bus_req.addr), DB_SPACING_EXP)
    |=> !db_valid_ff
  ) else $error("doorbell fired inside a stride gap");

  ready_field_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    bus_req.rd && hit(bus_req.addr, qcim_pkg::OFS_CAP_LO)
    |=> rd_data_ff[31:24] == READY_UNITS
  ) else $error("ready wait field wrong");

  arb_field_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    bus_req.rd && hit(bus_req.addr, qcim_pkg::OFS_CAP_LO)
    |=> rd_data_ff[18:17] == ARB_OPTS && rd_data_ff[23:19] == 5'h00
  ) else $error("arbitration field or reserved bits wrong");

  contig_field_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    bus_req.rd && hit(bus_req.addr, qcim_pkg::OFS_CAP_LO)
    |=> rd_data_ff[16] == CONTIG_NEED
  ) else $error("contiguous queue bit wrong");

  depth_field_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    bus_req.rd && hit(bus_req.addr, qcim_pkg::OFS_CAP_LO)
    |=> rd_data_ff[15:0] != 16'h0000
  ) else $error("queue depth reports fewer than two entries");

  version_halves_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    bus_req.rd && hit(bus_req.addr, qcim_pkg::OFS_VER)
    |=> rd_data_ff == {MAJOR_REV, MINOR_REV}
  ) else $error("version word halves wrong");

  mask_set_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    mset_we |=> mask_w == ($past(mask_w) | $past(bus_req.wdata))
  ) else $error("mask set did not or in written ones");

  mask_clr_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    mclr_we |=> mask_w == ($past(mask_w) & ~$past(bus_req.wdata))
  ) else $error("mask clear did not remove written ones");

  mask_read_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    bus_req.rd && (hit(bus_req.addr, qcim_pkg::OFS_MASK_SET) ||
      hit(bus_req.addr, qcim_pkg::OFS_MASK_CLR))
    |=> rd_data_ff == $past(mask_w)
  ) else $error("mask read does not show current mask");

  msix_hold_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    msix_mode && bus_req.wr && (hit(bus_req.addr, qcim_pkg::OFS_MASK_SET) ||
      hit(bus_req.addr, qcim_pkg::OFS_MASK_CLR))
    |=> $stable(mask_w)
  ) else $error("mask changed by a write in MSI-X mode");

  ro_stable_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ##1 $stable(cap_w) && $stable(ver_w)
  ) else $error("read-only word changed");

  pend_sticky_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    vec_event != 32'h0000_0000 |=> (pend_w & $past(vec_event)) ==
      $past(vec_event)
  ) else $error("vector event lost against a clear");

  irq_level_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !msix_mode && (pend_w & ~mask_w) == 32'h0000_0000 ##1 !msix_mode
    |-> !irq_ff
  ) else $error("interrupt raised with nothing unmasked");

  irq_raise_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (pend_w & ~mask_w) != 32'h0000_0000 |=> irq_ff
  ) else $error("unmasked pending vector gave no interrupt");

  irq_msix_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    msix_mode && pend_w != 32'h0000_0000 |=> irq_ff
  ) else $error("pending vector quiet in MSI-X mode");

  rd_idle_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !bus_req.rd |=> rd_data_ff == 32'h0000_0000
  ) else $error("read data not zero between reads");

  cap_hi_rsvd_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    bus_req.rd && hit(bus_req.addr, qcim_pkg::OFS_CAP_HI)
    |=> rd_data_ff[31:4] == 28'h000_0000
  ) else $error("reserved capability high bits not zero");

  db_once_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !db_hit |=> !db_valid_ff
  ) else $error("doorbell pulse without a doorbell write");

  db_hold_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !db_hit |=> $stable(db_ff)
  ) else $error("doorbell word changed without a write");

  mask_hold_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !mset_we && !mclr_we |=> $stable(mask_w)
  ) else $error("mask changed without a mask write");

  pend_clear_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    pend_we && vec_event == 32'h0000_0000
    |=> (pend_w & $past(bus_req.wdata)) == 32'h0000_0000
  ) else $error("pending bits survived a clear");

endmodule

// ===== hw/qcim_cap_rom.sv
// Purpose: holds the read-only capability and version words
// Assumes: field values are fixed by parameters at build time
// Notes: words are loaded at reset and never written afterwards

module qcim_cap_rom #(
  parameter logic [3:0] DB_SPACING_EXP = 4'h0,
  parameter logic [7:0] READY_UNITS = 8'h14,
  parameter logic [1:0] ARB_OPTS = 2'h0,
  parameter logic CONTIG_NEED = 1'b1,
  parameter logic [15:0] MAX_DEPTH = 16'h00ff,
  parameter logic [15:0] MAJOR_REV = 16'h00a5, // arbitrary value
  parameter logic [15:0] MINOR_REV = 16'h005a  // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  output logic [63:0] cap_ff,
  output logic [31:0] ver_ff
);

  // ==========================================================================
  // field assembly
  // a zero depth is illegal, so the smallest report is two entries
  localparam logic [15:0] DEPTH_EFF =
    (MAX_DEPTH == 16'h0000) ? 16'h0001 : MAX_DEPTH;

  localparam logic [63:0] CAP_WORD =
    (64'(DB_SPACING_EXP) << qcim_pkg::CAP_SPACING_LSB) |
    (64'(READY_UNITS) << qcim_pkg::CAP_READY_LSB) |
    (64'(ARB_OPTS) << qcim_pkg::CAP_ARB_LSB) |
    (64'(CONTIG_NEED) << qcim_pkg::CAP_CONTIG_BIT) |
    (64'(DEPTH_EFF) << qcim_pkg::CAP_DEPTH_LSB);

  // round robin always present, so it owns no bit; bits 36, 23:19 stay 0
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cap_ff <= CAP_WORD;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ver_ff <= {MAJOR_REV, MINOR_REV};
    end
  end

endmodule

// ===== hw/qcim_pkg.sv
// Purpose: shared constants and carriers of the queue controller cap/mask bank
// Assumes: 32-bit register words, 16-bit byte addresses
// Notes: capability field positions count within the 64-bit capability word

package qcim_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_CAP_LO = 16'h0000;
  localparam logic [15:0] OFS_CAP_HI = 16'h0004;
  localparam logic [15:0] OFS_VER = 16'h0008;
  localparam logic [15:0] OFS_MASK_SET = 16'h000c;
  localparam logic [15:0] OFS_MASK_CLR = 16'h0010;
  localparam logic [15:0] OFS_PEND = 16'h0018;
  localparam logic [15:0] OFS_IMODE = 16'h001c;
  localparam logic [15:0] OFS_DB_BASE = 16'h1000;

  // ==========================================================================
  // capability and version fields
  localparam int CAP_DEPTH_LSB = 0;
  localparam int CAP_CONTIG_BIT = 16;
  localparam int CAP_ARB_LSB = 17;
  localparam int CAP_READY_LSB = 24;
  localparam int CAP_SPACING_LSB = 32;
  localparam int VER_MAJ_LSB = 16;
  localparam int VER_MIN_LSB = 0;
  localparam int READY_UNIT_MS = 500;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_PEND = 32'h0000_0000;

  // ==========================================================================
  // carriers
  typedef enum logic [1:0] {
    QCIM_IRQ_PIN,
    QCIM_IRQ_MSI_ONE,
    QCIM_IRQ_MSI_MULTI,
    QCIM_IRQ_MSIX
  } qcim_imode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } qcim_req_t;

  typedef struct packed {
    logic [14:0] qid;
    logic is_cq;
    logic [31:0] value;
  } qcim_db_t;

endpackage

// ===== hw/qcim_vec_mask.sv
// Purpose: interrupt vector mask and sticky pending bits
// Assumes: write enables are single-cycle and mutually exclusive
// Notes: a vector event beats a clear of its pending bit

module qcim_vec_mask #(
  parameter int NVEC = 32
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic mask_set_we,
  input wire logic mask_clr_we,
  input wire logic pend_clr_we,
  input wire logic [NVEC-1:0] wr_bits,
  input wire logic [NVEC-1:0] vec_event,
  output logic [NVEC-1:0] mask_ff,
  output logic [NVEC-1:0] pend_ff
);

  // ==========================================================================
  // mask
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mask_ff <= qcim_pkg::RST_MASK[NVEC-1:0];
    end else if (mask_set_we) begin
      mask_ff <= mask_ff | wr_bits;
    end else if (mask_clr_we) begin
      mask_ff <= mask_ff & ~wr_bits;
    end
  end

  // ==========================================================================
  // pending
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pend_ff <= qcim_pkg::RST_PEND[NVEC-1:0];
    end else begin
      pend_ff <= (pend_ff & ~(pend_clr_we ? wr_bits : '0)) | vec_event;
    end
  end

endmodule

// ===== tb/qcim_host_model.sv
// Purpose: host software side of the register port, one access at a time
// Assumes: strobe bus on clk_sys, read data one cycle after the read strobe
// Notes: signals change only just after a rising edge, by non-blocking update

module qcim_host_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  output qcim_pkg::qcim_req_t bus_req,
  input wire logic [31:0] rd_data_ff
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // idle bus
  // the address is parked at its inverse after every access, and write data after
  // each write, so that a design that ignores the strobes cannot match by luck
  initial bus_req = '0;

  // set while the last interrupt mode this host selected is MSI-X
  bit msix_on = 1'b0;

  // ==========================================================================
  // accesses
  // holds off until reset is gone, bounded so a stuck reset cannot hang
  task automatic wait_ready(output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clk_sys);
      ok = (sys_rst === 1'b0);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    if (a == qcim_pkg::OFS_IMODE) begin
      msix_on = (d[1:0] == 2'h3);
    end
    @(posedge clk_sys);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    bus_req.addr <= ~a;
    bus_req.wdata <= ~d;
    // return after the edge's updates, so callers never race the outputs
    #1;
  endtask

  // mask registers are left alone while the per-vector table is in charge
  task automatic mask_wr(input logic [15:0] a, input logic [31:0] d,
                         output bit sent);
    sent = !msix_on;
    if (sent) begin
      wr(a, d);
    end
  endtask

  // what the host would put in a create-queue command, kept inside the caps
  task automatic plan_queue(input logic [31:0] cap_lo, input int entries,
                            output bit pc_flag, output bit fits);
    pc_flag = cap_lo[qcim_pkg::CAP_CONTIG_BIT];
    fits = (entries >= 2) &&
           (entries - 1 <= int'(cap_lo[15:0]));
  endtask

  // read data are taken only in the one cycle that they stand
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    bus_req.addr <= ~a;
    #1;
    d = rd_data_ff;
  endtask
endmodule

// ===== tb/tb_qcim_bank.sv
// Purpose: self-checking bench of the cap, version and vector mask bank
// Assumes: host model drives the register port, bench drives vector events
// Notes: build values other than doorbell spacing and contiguous flag differ from the defaults to catch hard-wired fields

module tb_qcim_bank;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // build values
  localparam logic [7:0] P_READY = 8'h3c;
  localparam logic [1:0] P_ARB = 2'b10;
  localparam logic [15:0] P_DEPTH = 16'h003f;
  localparam logic [15:0] P_MAJ = 16'h0b12; // arbitrary value
  localparam logic [15:0] P_MIN = 16'h0c34; // arbitrary value

  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] vec_event = '0;
  qcim_pkg::qcim_req_t bus_req;
  logic [31:0] rd_data_ff;
  logic [31:0] vec_mask_ff;
  logic irq_ff;
  logic db_valid_ff;
  qcim_pkg::qcim_db_t db_ff;
  int err_count = 0;
  int tests_run = 0;
  logic [31:0] rv;

  always #2 clk_sys = ~clk_sys;

  qcim_bank #(.DB_SPACING_EXP(4'h0), .READY_UNITS(P_READY),
    .ARB_OPTS(P_ARB),
    .CONTIG_NEED(1'b1), .MAX_DEPTH(P_DEPTH), .MAJOR_REV(P_MAJ),
    .MINOR_REV(P_MIN)) i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req),
    .vec_event(vec_event), .rd_data_ff(rd_data_ff),
    .vec_mask_ff(vec_mask_ff), .irq_ff(irq_ff),
    .db_valid_ff(db_valid_ff), .db_ff(db_ff));

  qcim_host_model i_host (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req),
    .rd_data_ff(rd_data_ff));

  // ==========================================================================
  // compare and report
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // settle one or more edges, then look after the updates have landed
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // event sampled at the second edge of this task
  task automatic pulse_ev(input logic [31:0] v);
    @(posedge clk_sys);
    vec_event <= v;
    @(posedge clk_sys);
    vec_event <= '0;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_caps();
    bit pc;
    bit fits;
    i_host.rd(qcim_pkg::OFS_CAP_LO, rv);
    chk32(rv, {P_READY, 5'h00, P_ARB, 1'b1, P_DEPTH}, "cap lo");
    i_host.plan_queue(rv, 64, pc, fits);
    chk1(pc, 1'b1, "host sets contiguous flag");
    chk1(fits, 1'b1, "64 entries fit");
    i_host.plan_queue(rv, 65, pc, fits);
    chk1(fits, 1'b0, "65 entries refused");
    chk32(rv & 32'h00f8_0000, 32'h0, "cap lo rsvd");
    chk1(rv[18], P_ARB[1], "vendor arb");
    chk1(rv[17], P_ARB[0], "optional arb, round robin has no bit");
    chk1(rv[16], 1'b1, "contig need");
    chk32({16'h0, rv[15:0]}, {16'h0, P_DEPTH}, "depth");
    // rd_data returns to zero in the cycle after the answer
    cycles(1);
    chk32(rd_data_ff, 32'h0, "rd idle");
    i_host.rd(qcim_pkg::OFS_CAP_HI, rv);
    chk32(rv, 32'h0000_0000, "cap hi stride exp 0");
    i_host.wr(qcim_pkg::OFS_CAP_LO, 32'hffff_ffff);
    i_host.wr(qcim_pkg::OFS_CAP_HI, 32'hffff_ffff);
    i_host.rd(qcim_pkg::OFS_CAP_LO, rv);
    chk32(rv, {P_READY, 5'h00, P_ARB, 1'b1, P_DEPTH}, "cap lo ro");
    i_host.rd(qcim_pkg::OFS_CAP_HI, rv);
    chk32(rv, 32'h0, "cap hi ro, bit 36 zero");
    $display("test caps done");
  endtask

  task automatic t_version();
    i_host.rd(qcim_pkg::OFS_VER, rv);
    chk32(rv, {P_MAJ, P_MIN}, "version");
    i_host.wr(qcim_pkg::OFS_VER, 32'h0000_0000);
    i_host.rd(qcim_pkg::OFS_VER, rv);
    chk32(rv, {P_MAJ, P_MIN}, "version ro");
    i_host.rd(16'h0014, rv);
    chk32(rv, 32'h0, "unmapped read");
    $display("test version done");
  endtask

  task automatic t_mask();
    i_host.rd(qcim_pkg::OFS_MASK_SET, rv);
    chk32(rv, qcim_pkg::RST_MASK, "mask reset");
    i_host.wr(qcim_pkg::OFS_MASK_SET, 32'h8000_0101);
    i_host.wr(qcim_pkg::OFS_MASK_SET, 32'h0000_0010);
    chk32(vec_mask_ff, 32'h8000_0111, "w1s keeps zeros");
    i_host.rd(qcim_pkg::OFS_MASK_SET, rv);
    chk32(rv, 32'h8000_0111, "read via set");
    i_host.wr(qcim_pkg::OFS_MASK_CLR, 32'h8000_0001);
    i_host.rd(qcim_pkg::OFS_MASK_CLR, rv);
    chk32(rv, 32'h0000_0110, "w1c keeps zeros");
    i_host.rd(qcim_pkg::OFS_MASK_SET, rv);
    chk32(rv, 32'h0000_0110, "one shared mask");
    i_host.wr(qcim_pkg::OFS_MASK_CLR, 32'hffff_ffff);
    $display("test mask done");
  endtask

  task automatic t_irq();
    bit sent;
    for (int m = 0; m < 3; m++) begin
      i_host.wr(qcim_pkg::OFS_IMODE, 32'(m));
      pulse_ev(32'h0000_0008);
      cycles(1);
      chk1(irq_ff, 1'b1, "unmasked irq");
      i_host.wr(qcim_pkg::OFS_PEND, 32'h0000_0008);
      cycles(1);
      chk1(irq_ff, 1'b0, "irq after clear");
      i_host.wr(qcim_pkg::OFS_MASK_SET, 32'h0000_0020);
      pulse_ev(32'h0000_0020);
      cycles(2);
      chk1(irq_ff, 1'b0, "masked vector quiet");
      i_host.rd(qcim_pkg::OFS_PEND, rv);
      chk32(rv, 32'h0000_0020, "masked still pending");
      i_host.wr(qcim_pkg::OFS_MASK_CLR, 32'h0000_0020);
      cycles(1);
      chk1(irq_ff, 1'b1, "unmask raises irq");
      i_host.wr(qcim_pkg::OFS_PEND, 32'h0000_0020);
    end
    // a vector masked before the switch still interrupts in msix
    i_host.wr(qcim_pkg::OFS_MASK_SET, 32'h0000_0040);
    i_host.wr(qcim_pkg::OFS_IMODE, 32'h3);
    pulse_ev(32'h0000_0040);
    cycles(1);
    chk1(irq_ff, 1'b1, "msix ignores mask");
    i_host.mask_wr(qcim_pkg::OFS_MASK_CLR, 32'h0000_0040, sent);
    chk1(sent, 1'b0, "host keeps off mask in msix");
    // deliberate misuse: the bank must drop mask writes in this mode
    i_host.wr(qcim_pkg::OFS_MASK_SET, 32'hffff_ffff);
    i_host.rd(qcim_pkg::OFS_MASK_SET, rv);
    chk32(rv, 32'h0000_0040, "mask untouched in msix");
    i_host.wr(qcim_pkg::OFS_PEND, 32'h0000_0040);
    i_host.wr(qcim_pkg::OFS_IMODE, 32'h0);
    i_host.mask_wr(qcim_pkg::OFS_MASK_CLR, 32'h0000_0040, sent);
    chk1(sent, 1'b1, "host mask access back");
    chk32(vec_mask_ff, 32'h0, "mask clear after msix");
    $display("test irq done");
  endtask

  task automatic t_doorbell();
    i_host.wr(16'h1004, 32'hdead_beef);
    chk1(db_valid_ff, 1'b1, "db pulse packed");
    chk32({16'h0, db_ff.qid, db_ff.is_cq}, 32'h1, "db slot 1");
    chk32(db_ff.value, 32'hdead_beef, "db full word");
    cycles(1);
    chk1(db_valid_ff, 1'b0, "db one cycle");
    i_host.wr(16'h1018, 32'h1234_5678);
    chk32({16'h0, db_ff.qid, db_ff.is_cq}, 32'h6, "db slot 6");
    i_host.wr(16'h1002, 32'h0000_0001);
    chk1(db_valid_ff, 1'b0, "misaligned ignored");
    chk32(db_ff.value, 32'h1234_5678, "db held");
    $display("test doorbell done");
  endtask

  // mid-run reset with mask, mode and pending all away from reset values
  task automatic t_reset();
    i_host.wr(qcim_pkg::OFS_MASK_SET, 32'h0000_0c00);
    i_host.wr(qcim_pkg::OFS_IMODE, 32'h2);
    pulse_ev(32'h0000_0001);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cycles(1);
    chk32(vec_mask_ff, qcim_pkg::RST_MASK, "mask after reset");
    chk1(irq_ff, 1'b0, "irq after reset");
    i_host.rd(qcim_pkg::OFS_PEND, rv);
    chk32(rv, qcim_pkg::RST_PEND, "pending after reset");
    i_host.rd(qcim_pkg::OFS_IMODE, rv);
    chk32(rv, 32'h0, "mode after reset");
    $display("test reset done");
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    bit ok;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    i_host.wait_ready(ok);
    chk1(ok, 1'b1, "reset release");
    chk1(irq_ff, 1'b0, "irq reset");
    t_caps();
    t_version();
    t_mask();
    t_irq();
    t_doorbell();
    t_reset();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("ERROR t=%0t run did not finish", $time);
    summarize();
  end
endmodule
